// ===== syn_pkg.sv
package syn_pkg;

  // --------------------------------------------------------------------
  // Field widths
  // --------------------------------------------------------------------
  localparam int M_W  = 9;
  localparam int N_W  = 2;
  localparam int T_W  = 3;
  localparam int SH_W = 14;

  // Serial image, first bit shifted in ends at the top
  typedef struct packed {
    logic [T_W-1:0] tsel;
    logic [N_W-1:0] nsel;
    logic [M_W-1:0] mdiv;
  } syn_cfg_s;

  // Pull-ups make undriven divisor inputs read as ones
  localparam syn_cfg_s CFG_RST = '{tsel: 3'h0, nsel: 2'h3, mdiv: 9'h1ff};

  // --------------------------------------------------------------------
  // Reference and output dividers
  // --------------------------------------------------------------------
  localparam int          REF_DIV_W = 5;
  localparam logic [4:0]  REF_DIV   = 5'h10;
  localparam int          NDIV_W    = 4;
  localparam logic [3:0]  NDIV_ONE  = 4'h1;

  // --------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------
  localparam logic [7:0]  OFS_CFG     = 8'h00;
  localparam logic [7:0]  OFS_SHIFT   = 8'h04;
  localparam logic [7:0]  OFS_CTRL    = 8'h08;
  localparam int          CTRL_PD_BIT = 0;
  localparam int          CTRL_TE_BIT = 1;
  localparam int          STAT_UP_BIT = 16;
  localparam int          STAT_DN_BIT = 17;
  localparam int          STAT_PL_BIT = 18;
  localparam logic [1:0]  CTRL_RST    = 2'h3;

  // --------------------------------------------------------------------
  // Test observation selections
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    TS_STATIC = 3'b000,
    TS_REF    = 3'b001,
    TS_FB     = 3'b010,
    TS_VCO    = 3'b011,
    TS_OUT    = 3'b100,
    TS_PDUP   = 3'b101,
    TS_SCLK   = 3'b110,
    TS_XTAL   = 3'b111
  } syn_tsel_e;

endpackage

// ===== syn_edge_det.sv
module syn_edge_det (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Level and its edges
  input  wire logic sig_in,
  output logic      rise,
  output logic      fall
);

  logic sig_q_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_q_r <= 1'b0;
    end else begin
      sig_q_r <= sig_in;
    end
  end

  assign rise = sig_in & ~sig_q_r;
  assign fall = ~sig_in & sig_q_r;

endmodule // syn_edge_det

// ===== syn_edge_div.sv
module syn_edge_div #(
  parameter int W = 9
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Divided level
  input  wire logic         sig_in,
  input  wire logic [W-1:0] div,
  output logic              sig_out
);

  logic         sig_q_r;
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  wire rise = sig_in & ~sig_q_r;
  wire pass = div < W'(2);
  wire wrap = cnt_r >= div - W'(1);
  // High for the first half of the count: even ratios give 50% duty
  wire half = cnt_nxt < (div >> 1);

  assign cnt_nxt = (!rise || pass) ? cnt_r : (wrap ? '0 : cnt_r + W'(1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_q_r <= 1'b0;
      cnt_r   <= '0;
      sig_out <= 1'b0;
    end else begin
      sig_q_r <= sig_in;
      cnt_r   <= cnt_nxt;
      sig_out <= pass ? sig_in : half;
    end
  end

endmodule // syn_edge_div

// ===== syn_divider_cfg.sv
// Local design decisions: the address map and the APB slave port.
module syn_divider_cfg (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Parallel configuration
  input  wire logic        p_load,
  input  wire logic [8:0]  m_in,
  input  wire logic [8:0]  m_driven,
  input  wire logic [1:0]  n_in,
  input  wire logic [1:0]  n_driven,
  // Serial configuration
  input  wire logic        s_clock,
  input  wire logic        s_data,
  input  wire logic        s_load,
  // Oscillator levels
  input  wire logic        xtal_in,
  input  wire logic        vco_in,
  // Loop and clock outputs
  output logic             ref_clk,
  output logic             fb_clk,
  output logic             pd_up,
  output logic             pd_down,
  output logic             synth_clock_out,
  output logic             test_out
);

  // --------------------------------------------------------------------
  // Edges of the strobes
  // --------------------------------------------------------------------
  logic pl_rise, sl_fall, sc_rise;

  syn_edge_det u_pl_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .sig_in  (p_load),
    .rise    (pl_rise),
    .fall    ()
  );

  syn_edge_det u_sl_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .sig_in  (s_load),
    .rise    (),
    .fall    (sl_fall)
  );

  syn_edge_det u_sc_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .sig_in  (s_clock),
    .rise    (sc_rise),
    .fall    ()
  );

  // --------------------------------------------------------------------
  // Configuration path
  // --------------------------------------------------------------------
  logic [syn_pkg::SH_W-1:0] shreg_r, shreg_nxt;
  syn_pkg::syn_cfg_s        cfg_r, cfg_nxt, par_cfg, ser_cfg;
  logic [8:0]               m_eff;
  logic [1:0]               n_eff;

  assign m_eff = m_in | ~m_driven;
  assign n_eff = n_in | ~n_driven;

  assign par_cfg = '{tsel: 3'h0, nsel: n_eff, mdiv: m_eff};
  assign ser_cfg = syn_pkg::syn_cfg_s'(shreg_r);

  wire par_take = !p_load || pl_rise;
  wire ser_take = p_load && !pl_rise && sl_fall;

  assign shreg_nxt = sc_rise ? {shreg_r[syn_pkg::SH_W-2:0], s_data}
                             : shreg_r;
  assign cfg_nxt = par_take ? par_cfg : (ser_take ? ser_cfg : cfg_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg_r <= '0;
      cfg_r   <= syn_pkg::CFG_RST;
    end else begin
      shreg_r <= shreg_nxt;
      cfg_r   <= cfg_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Dividers and phase detector
  // --------------------------------------------------------------------
  logic [syn_pkg::NDIV_W-1:0] n_ratio;
  logic                       ref_rise_q_r, fb_q_r;
  logic [1:0]                 ctrl_r;

  assign n_ratio = syn_pkg::NDIV_ONE << cfg_r.nsel;

  syn_edge_div #(.W(syn_pkg::REF_DIV_W)) u_ref_div (
    .pclk    (pclk),
    .presetn (presetn),
    .sig_in  (xtal_in),
    .div     (syn_pkg::REF_DIV),
    .sig_out (ref_clk)
  );

  syn_edge_div #(.W(syn_pkg::M_W)) u_fb_div (
    .pclk    (pclk),
    .presetn (presetn),
    .sig_in  (vco_in),
    .div     (cfg_r.mdiv),
    .sig_out (fb_clk)
  );

  syn_edge_div #(.W(syn_pkg::NDIV_W)) u_out_div (
    .pclk    (pclk),
    .presetn (presetn),
    .sig_in  (vco_in),
    .div     (n_ratio),
    .sig_out (synth_clock_out)
  );

  wire ref_up  = ref_clk & ~ref_rise_q_r;
  wire fb_up   = fb_clk & ~fb_q_r;
  wire pd_en   = ctrl_r[syn_pkg::CTRL_PD_BIT];
  // Both edges together clear, like a three-state detector's reset path
  wire up_nxt  = pd_en && ((ref_up && !fb_up) || (pd_up && !fb_up));
  wire dn_nxt  = pd_en && ((fb_up && !ref_up) || (pd_down && !ref_up));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_rise_q_r <= 1'b0;
      fb_q_r       <= 1'b0;
      pd_up        <= 1'b0;
      pd_down      <= 1'b0;
    end else begin
      ref_rise_q_r <= ref_clk;
      fb_q_r       <= fb_clk;
      pd_up        <= up_nxt;
      pd_down      <= dn_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Test observation pin
  // --------------------------------------------------------------------
  logic test_src;
  wire  test_en = ctrl_r[syn_pkg::CTRL_TE_BIT];

  always_comb begin
    case (syn_pkg::syn_tsel_e'(cfg_r.tsel))
      syn_pkg::TS_STATIC: test_src = 1'b0;
      syn_pkg::TS_REF:    test_src = ref_clk;
      syn_pkg::TS_FB:     test_src = fb_clk;
      syn_pkg::TS_VCO:    test_src = vco_in;
      syn_pkg::TS_OUT:    test_src = synth_clock_out;
      syn_pkg::TS_PDUP:   test_src = pd_up;
      syn_pkg::TS_SCLK:   test_src = s_clock;
      syn_pkg::TS_XTAL:   test_src = xtal_in;
      default:            test_src = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_out <= 1'b0;
    end else begin
      test_out <= test_en & test_src;
    end
  end

  // --------------------------------------------------------------------
  // APB slave, one wait state so read data leaves a flop
  // --------------------------------------------------------------------
  logic [31:0] rd_val;
  wire         acc_first = psel && penable && !pready;
  wire         acc_done  = psel && penable && pready;
  wire         hit_cfg   = paddr == syn_pkg::OFS_CFG;
  wire         hit_shift = paddr == syn_pkg::OFS_SHIFT;
  wire         hit_ctrl  = paddr == syn_pkg::OFS_CTRL;
  wire         hit       = hit_cfg || hit_shift || hit_ctrl;
  wire         ctrl_wr   = acc_done && pwrite && hit_ctrl;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit_cfg) begin
      rd_val[syn_pkg::SH_W-1:0]  = cfg_r;
      rd_val[syn_pkg::STAT_UP_BIT] = pd_up;
      rd_val[syn_pkg::STAT_DN_BIT] = pd_down;
      rd_val[syn_pkg::STAT_PL_BIT] = p_load;
    end else if (hit_shift) begin
      rd_val[syn_pkg::SH_W-1:0] = shreg_r;
    end else if (hit_ctrl) begin
      rd_val[1:0] = ctrl_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      ctrl_r  <= syn_pkg::CTRL_RST;
    end else begin
      pready  <= acc_first;
      pslverr <= acc_first && !hit;
      prdata  <= (acc_first && !pwrite) ? rd_val : 32'h0000_0000;
      if (ctrl_wr) begin
        ctrl_r <= pwdata[1:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  shift_adv_a: assert property (sc_rise |=>
    shreg_r == {$past(shreg_r[syn_pkg::SH_W-2:0]), $past(s_data)})
    else $error("shift register did not advance");

  serial_load_a: assert property (ser_take |=> cfg_r == $past(shreg_r))
    else $error("serial transfer did not load all fields");

  par_transp_a: assert property (!p_load |=>
    cfg_r.mdiv == $past(m_eff) && cfg_r.nsel == $past(n_eff))
    else $error("parallel latches not transparent");

  test_zero_a: assert property (!p_load |=> cfg_r.tsel == 3'h0)
    else $error("test select not forced to zero");

  par_prio_a: assert property (p_load && !pl_rise && !sl_fall |=>
    $stable(cfg_r))
    else $error("configuration changed without a load");

  pullup_a: assert property (!p_load && !m_driven[0] && !n_driven[1] |=>
    cfg_r.mdiv[0] && cfg_r.nsel[1])
    else $error("undriven input not read as one");

  div_one_a: assert property (cfg_r.nsel == 2'h0 |=>
    synth_clock_out == $past(vco_in))
    else $error("divide by one does not follow the oscillator");

  test_sel_a: assert property (cfg_r.tsel == 3'h3 && test_en |=>
    test_out == $past(vco_in))
    else $error("test pin does not show the selection");

  apb_ready_a: assert property (acc_first |=> pready ##1 !pready)
    else $error("APB answer not one wait state");

  apb_err_a: assert property (acc_first && !hit |=>
    pready && pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  ctrl_wr_a: assert property (ctrl_wr |=> ctrl_r == $past(pwdata[1:0]))
    else $error("control write did not land");

  par_cap_a: assert property (pl_rise |=>
    cfg_r.mdiv == $past(m_eff) && cfg_r.nsel == $past(n_eff))
    else $error("parallel strobe did not capture inputs");

  pd_excl_a: assert property (!(pd_up && pd_down))
    else $error("detector raises both outputs");

  pd_off_a: assert property (!pd_en |=> !pd_up && !pd_down)
    else $error("disabled detector still drives");

  ser_load_c: cover property (ser_take);
  par_cap_c: cover property (pl_rise);
  ref_edge_c: cover property (ref_up ##1 pd_up);
  ctrl_wr_c: cover property (ctrl_wr);
  tsel_vco_c: cover property (test_en && cfg_r.tsel == 3'h3);

endmodule // syn_divider_cfg

// ===== syn_host_model.sv
module syn_host_model #(
  parameter int HALF = 5
) (
  // Clock and request
  input  wire logic        pclk,
  input  wire logic        go,
  input  wire logic [13:0] word,
  // Serial link
  output logic             s_clock,
  output logic             s_data,
  output logic             s_load,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------------
  // Frame sender
  // --------------------------------------------------------------------
  // HALF pclk cycles per level keeps the shift clock at 10 MHz
  initial begin
    s_clock = 1'b0;
    s_data  = 1'b0;
    s_load  = 1'b0;
    busy    = 1'b0;
    forever begin
      @(posedge pclk);
      if (go === 1'b1) begin
        busy <= 1'b1;
        for (int i = 13; i >= 0; i--) begin
          s_data <= word[i];
          repeat (HALF) @(posedge pclk);
          s_clock <= 1'b1;
          repeat (HALF) @(posedge pclk);
          s_clock <= 1'b0;
        end
        // Released data line shows the inverse so stale bits never pass
        s_data <= ~word[0];
        s_load <= 1'b1;
        repeat (HALF) @(posedge pclk);
        s_load <= 1'b0;
        repeat (HALF) @(posedge pclk);
        busy <= 1'b0;
      end
    end
  end
endmodule // syn_host_model

// ===== synth_divider_config_port_tb_top.sv
module synth_divider_config_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [8:0]  m;
    logic [8:0]  md;
    logic [1:0]  n;
    logic [1:0]  nd;
    logic [13:0] cfg;
    logic [7:0]  half;
  } syn_row_s;
  // Half period of synth_clock_out with a four cycle vco
  localparam syn_row_s ROWS [4] = '{
    '{9'h105, 9'h1ff, 2'h1, 2'h3, 14'h0305, 8'h04},
    '{9'h000, 9'h000, 2'h0, 2'h0, 14'h07ff, 8'h10},
    '{9'h0c8, 9'h0ff, 2'h2, 2'h1, 14'h05c8, 8'h08},
    '{9'h190, 9'h1ff, 2'h0, 2'h3, 14'h0190, 8'h02}
  };
  // Test pin period per select with divisor 7 and ratio four, 0 = skip
  localparam int TPER [8] = '{0, 32, 28, 4, 16, 0, 0, 2};

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0]  m_in, m_driven;
  logic [1:0]  n_in, n_driven, vdiv;
  logic        p_load, s_clock, s_data, s_load, xtal_in, vco_in;
  logic        ref_clk, fb_clk, pd_up, pd_down, synth_clock_out, test_out;
  logic        go, busy, er;
  logic [13:0] word;
  int          error_cnt, check_count, cyc, hi, lo;

  syn_divider_cfg syn_divider_cfg_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .p_load(p_load), .m_in(m_in),
    .m_driven(m_driven), .n_in(n_in), .n_driven(n_driven),
    .s_clock(s_clock), .s_data(s_data), .s_load(s_load),
    .xtal_in(xtal_in), .vco_in(vco_in), .ref_clk(ref_clk),
    .fb_clk(fb_clk), .pd_up(pd_up), .pd_down(pd_down),
    .synth_clock_out(synth_clock_out), .test_out(test_out));

  syn_host_model syn_host_model_i (
    .pclk(pclk), .go(go), .word(word), .s_clock(s_clock),
    .s_data(s_data), .s_load(s_load), .busy(busy));

  // --------------------------------------------------------------------
  // Clocks, oscillators and timeout
  // --------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    xtal_in <= ~xtal_in;
    vdiv    <= vdiv + 2'h1;
    vco_in  <= vdiv[1];
    cyc     <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      conclude();
    end
  end

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task conclude();
    if (error_cnt == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task chk_cnt(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rcfg(input logic [13:0] exp, input logic pl);
    apb(1'b0, syn_pkg::OFS_CFG, 32'h0);
    chk_word(rd & 32'h0004_3fff, {13'h0, pl, 4'h0, exp});
  endtask

  function automatic logic pick(input int k);
    case (k)
      0:       pick = ref_clk;
      1:       pick = fb_clk;
      2:       pick = synth_clock_out;
      4:       pick = pd_up | pd_down;
      default: pick = test_out;
    endcase
  endfunction

  // Bounded so a stuck output ends in a mismatch, not a hang
  task meas(input int k);
    int n;
    hi = 0;
    lo = 0;
    n  = 0;
    while (pick(k) !== 1'b0 && n < 4000) begin @(posedge pclk); n++; end
    while (pick(k) !== 1'b1 && n < 4000) begin @(posedge pclk); n++; end
    while (pick(k) === 1'b1 && n < 4000) begin @(posedge pclk); hi++; n++; end
    while (pick(k) === 1'b0 && n < 4000) begin @(posedge pclk); lo++; n++; end
  endtask

  task watch(input int k, input int c);
    hi = 0;
    repeat (c) begin
      @(posedge pclk);
      if (pick(k) !== 1'b0) hi++;
    end
  endtask

  task send(input logic [13:0] w);
    @(posedge pclk);
    word <= w;
    go   <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    for (int n = 0; n < 400; n++) begin
      @(posedge pclk);
      if (n > 2 && busy === 1'b0) break;
    end
  endtask

  // --------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    p_load  = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {m_in, m_driven, n_in, n_driven, word, go} = '0;
    {xtal_in, vdiv, vco_in} = '0;
    {error_cnt, check_count, cyc} = '0;
    repeat (8) @(posedge pclk);
    chk_word({29'h0, ref_clk, synth_clock_out, test_out}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, syn_pkg::OFS_CTRL, 32'h0);
    chk_word(rd, {30'h0, syn_pkg::CTRL_RST});
    rcfg(14'h07ff, 1'b0);
    for (int i = 0; i < 4; i++) begin
      m_in     <= ROWS[i].m;
      m_driven <= ROWS[i].md;
      n_in     <= ROWS[i].n;
      n_driven <= ROWS[i].nd;
      rcfg(ROWS[i].cfg, 1'b0);
      meas(2);
      chk_cnt(hi, ROWS[i].half);
      chk_cnt(lo, ROWS[i].half);
    end
    m_in     <= 9'h005;
    m_driven <= 9'h1ff;
    n_in     <= 2'h1;
    n_driven <= 2'h3;
    repeat (3) @(posedge pclk);
    p_load <= 1'b1;
    repeat (2) @(posedge pclk);
    m_in <= 9'h0aa;
    rcfg(14'h0205, 1'b1);
    meas(1);
    chk_cnt(hi + lo, 20);
    meas(0);
    chk_cnt(hi, 16);
    chk_cnt(lo, 16);
    send(14'h0c07);
    rcfg(14'h0c07, 1'b1);
    apb(1'b0, syn_pkg::OFS_SHIFT, 32'h0);
    chk_word(rd & 32'h0000_ffff, 32'h0c07);
    meas(1);
    chk_cnt(hi + lo, 28);
    meas(3);
    chk_cnt(hi + lo, 32);
    for (int t = 2; t < 8; t++) begin
      if (TPER[t] > 0) begin
        send({3'(t), 11'h407});
        meas(3);
        chk_cnt(hi + lo, TPER[t]);
      end
    end
    p_load <= 1'b0;
    send(14'h3fff);
    rcfg(14'h02aa, 1'b0);
    watch(3, 40);
    chk_cnt(hi, 0);
    apb(1'b1, 8'h0c, 32'h1);
    chk_word({31'h0, er}, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    chk_word({rd[30:0], er}, 32'h1);
    apb(1'b1, syn_pkg::OFS_CTRL, 32'h1);
    apb(1'b0, syn_pkg::OFS_CTRL, 32'h0);
    chk_word(rd, 32'h1);
    watch(4, 64);
    chk_cnt(hi > 0, 1);
    apb(1'b1, syn_pkg::OFS_CFG, 32'h0);
    chk_word({31'h0, er}, 32'h0);
    rcfg(14'h02aa, 1'b0);
    apb(1'b1, syn_pkg::OFS_CTRL, 32'h0);
    // Detector still runs one edge on the old enable
    @(posedge pclk);
    watch(4, 40);
    chk_cnt(hi, 0);
    presetn <= 1'b0;
    @(posedge pclk);
    chk_word({28'h0, pready, ref_clk, synth_clock_out, test_out}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, syn_pkg::OFS_CTRL, 32'h0);
    chk_word(rd, {30'h0, syn_pkg::CTRL_RST});
    apb(1'b0, syn_pkg::OFS_SHIFT, 32'h0);
    chk_word(rd, 32'h0);
    conclude();
  end
endmodule // synth_divider_config_port_tb_top
